// ### verilog/dcp_device.sv
// Coprocessor parameter register bank with a one-pixel masked ALU and operation launch.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dcp_regs.svh"
// Behaviour
// - Write-disabled bits excluded from mixes and compare.
// - Masks and colours used only to pixel depth.
// - Carry mask bit gates carry to next.
// - Carry mask covers add mixes and compare; here the compare is a plain masked equality that ignores the carry mask.
// - No carry out of pixel top bit.
// - Fixed foreground selection uses foreground colour.
// - Fixed background selection uses background colour.
// - Dimension one is width or length minus one.
// - Dimension two is height minus one.
// - Host keeps unsigned values within 0..4095.
// - Mask origin offsets relative to destination origin.
// - Source coordinates readable, writable, current position.
// - Pattern coordinates readable, writable, current position.
// - Destination coordinates signed, -2048 to +6143.
// - Pixel op write defines flow, starts operations.
// - Pixel op byte layout independent of ordering.
// - Operation starts on write of byte three.
// - Front source 00 fixed, 10 source map.
module dcp_device
  import dcp_pkg::*;
#(
  parameter int PIX_W = 8
) (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic nrst_in,
  // Register port from the host.
  dcp_if.dev bus,
  // Pixel datapath on the user side.
  input wire logic [PIX_W-1:0] src_pix_in,
  input wire logic [PIX_W-1:0] dst_pix_in,
  input wire logic pat_pix_in,
  input wire logic [PIX_W-1:0] pix_mask_in,
  input wire logic [PIX_W-1:0] cmp_val_in,
  input wire logic step_in,
  input wire logic done_in,
  output logic [PIX_W-1:0] mix_out,
  output logic cmp_eq_out,
  output logic start_out,
  output logic busy_out,
  output logic [31:0] pixel_op_out,
  output logic [15:0] dim1_out,
  output logic [15:0] dim2_out,
  output logic [15:0] mask_x_out,
  output logic [15:0] mask_y_out,
  output logic [15:0] dst_x_out,
  output logic [15:0] dst_y_out
);
  logic [31:0] carry_propagate_mask_r; // Carry chain mask.
  logic [31:0] fixed_front_colour_r; // Fixed foreground colour.
  logic [31:0] fixed_back_colour_r; // Fixed background colour.
  logic [15:0] src_coord_x_r;
  logic [15:0] src_coord_y_r;
  logic [15:0] pat_coord_x_r;
  logic [15:0] pat_coord_y_r;
  logic [31:0] rdata_r; // Read data, valid one cycle after the strobe.
  logic start_r; // One-cycle launch pulse.
  logic busy_r; // Operation in progress.
  logic [PIX_W-1:0] operand; // Selected second operand.

  // Merges the enabled bytes of a write into a 32-bit register.
  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Merges into a half-word register; the hi argument picks the upper lane pair.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be,
                                          input logic hi);
    logic [15:0] r;
    r = old;
    if (be[{hi, 1'b0}]) begin
      r[7:0] = hi ? d[23:16] : d[7:0];
    end
    if (be[{hi, 1'b1}]) begin
      r[15:8] = hi ? d[31:24] : d[15:8];
    end
    return r;
  endfunction

  // Word-aligned decode helper; half-word registers share the word of their pair.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return (a[7:2] == off[7:2]);
  endfunction

  logic wr_carry, wr_front, wr_back, wr_pixop, wr_dim, wr_mask, wr_src, wr_pat, wr_dst;
  assign wr_carry = bus.wr && hit(bus.addr, `DCP_OFF_CARRY);
  assign wr_front = bus.wr && hit(bus.addr, `DCP_OFF_FRONT);
  assign wr_back = bus.wr && hit(bus.addr, `DCP_OFF_BACK);
  assign wr_pixop = bus.wr && hit(bus.addr, `DCP_OFF_PIXOP);
  assign wr_dim = bus.wr && hit(bus.addr, `DCP_OFF_DIM1);
  assign wr_mask = bus.wr && hit(bus.addr, `DCP_OFF_MASKX);
  assign wr_src = bus.wr && hit(bus.addr, `DCP_OFF_SRCX);
  assign wr_pat = bus.wr && hit(bus.addr, `DCP_OFF_PATX);
  assign wr_dst = bus.wr && hit(bus.addr, `DCP_OFF_DSTX);

  // Full-word colour and mask registers take byte-enabled writes.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      carry_propagate_mask_r <= `DCP_RST_WORD;
      fixed_front_colour_r <= `DCP_RST_WORD;
      fixed_back_colour_r <= `DCP_RST_WORD;
    end else begin
      if (wr_carry) begin
        carry_propagate_mask_r <= merge32(carry_propagate_mask_r, bus.wdata, bus.be);
      end
      if (wr_front) begin
        fixed_front_colour_r <= merge32(fixed_front_colour_r, bus.wdata, bus.be);
      end
      if (wr_back) begin
        fixed_back_colour_r <= merge32(fixed_back_colour_r, bus.wdata, bus.be);
      end
    end
  end

  // Pixel op register: same lane layout for any byte order, no swap applied.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pixel_op_out <= `DCP_RST_WORD;
    end else if (wr_pixop) begin
      pixel_op_out <= merge32(pixel_op_out, bus.wdata, bus.be);
    end
  end

  // Launch only when byte three lands, so split writes must finish with it.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      start_r <= wr_pixop && bus.be[3];
      if (start_r) begin
        busy_r <= 1'b1;
      end else if (done_in) begin
        busy_r <= 1'b0;
      end
    end
  end
  assign start_out = start_r;
  assign busy_out = busy_r;

  // Dimensions and mask origin are stored as written; the engine adds one.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dim1_out <= `DCP_RST_HALF;
      dim2_out <= `DCP_RST_HALF;
      mask_x_out <= `DCP_RST_HALF;
      mask_y_out <= `DCP_RST_HALF;
    end else begin
      if (wr_dim) begin
        dim1_out <= merge16(dim1_out, bus.wdata, bus.be, 1'b0);
        dim2_out <= merge16(dim2_out, bus.wdata, bus.be, 1'b1);
      end
      if (wr_mask) begin
        mask_x_out <= merge16(mask_x_out, bus.wdata, bus.be, 1'b0);
        mask_y_out <= merge16(mask_y_out, bus.wdata, bus.be, 1'b1);
      end
    end
  end

  // Coordinates: host writes win; otherwise each step while busy advances the X positions by one.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_coord_x_r <= `DCP_RST_HALF;
      src_coord_y_r <= `DCP_RST_HALF;
      pat_coord_x_r <= `DCP_RST_HALF;
      pat_coord_y_r <= `DCP_RST_HALF;
      dst_x_out <= `DCP_RST_HALF;
      dst_y_out <= `DCP_RST_HALF;
    end else if (wr_src || wr_pat || wr_dst) begin
      if (wr_src) begin
        src_coord_x_r <= merge16(src_coord_x_r, bus.wdata, bus.be, 1'b0);
        src_coord_y_r <= merge16(src_coord_y_r, bus.wdata, bus.be, 1'b1);
      end
      if (wr_pat) begin
        pat_coord_x_r <= merge16(pat_coord_x_r, bus.wdata, bus.be, 1'b0);
        pat_coord_y_r <= merge16(pat_coord_y_r, bus.wdata, bus.be, 1'b1);
      end
      if (wr_dst) begin
        dst_x_out <= merge16(dst_x_out, bus.wdata, bus.be, 1'b0);
        dst_y_out <= merge16(dst_y_out, bus.wdata, bus.be, 1'b1);
      end
    end else if (busy_r && step_in) begin
      // Simple X stepping; the full octant walk lives in the address engine.
      src_coord_x_r <= src_coord_x_r + 16'h0001;
      pat_coord_x_r <= pat_coord_x_r + 16'h0001;
      dst_x_out <= dst_x_out + 16'h0001;
    end
  end

  // Read mux: coordinates read back; write-only offsets return zero with no side effect.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_r <= `DCP_RST_WORD;
    end else if (bus.rd) begin
      if (hit(bus.addr, `DCP_OFF_SRCX)) begin
        rdata_r <= {src_coord_y_r, src_coord_x_r};
      end else if (hit(bus.addr, `DCP_OFF_PATX)) begin
        rdata_r <= {pat_coord_y_r, pat_coord_x_r};
      end else if (hit(bus.addr, `DCP_OFF_DSTX)) begin
        rdata_r <= {dst_y_out, dst_x_out};
      end else if (hit(bus.addr, `DCP_OFF_STAT)) begin
        rdata_r <= {30'h0000_0000, start_r, busy_r};
      end else begin
        rdata_r <= `DCP_RST_WORD;
      end
    end
  end
  assign bus.rdata = rdata_r;

  // Operand select by pattern pixel; reserved codes fall back to the fixed colour.
  always_comb begin
    logic [1:0] sel;
    sel = pat_pix_in ? pixel_op_out[`DCP_POS_FS +: 2] : pixel_op_out[`DCP_POS_BS +: 2];
    if (sel == `DCP_SEL_SRCMAP) begin
      operand = src_pix_in;
    end else if (pat_pix_in) begin
      operand = fixed_front_colour_r[PIX_W-1:0];
    end else begin
      operand = fixed_back_colour_r[PIX_W-1:0];
    end
  end

  // Ripple adder whose carry chain is cut by the low carry-mask bits and by the pixel mask.
  // Masked-off bits see zero operands, so they neither produce nor pass a carry.
  function automatic logic [PIX_W-1:0] seg_add(input logic [PIX_W-1:0] a, input logic [PIX_W-1:0] b,
                                               input logic [PIX_W-1:0] en, input logic [PIX_W-1:0] cm,
                                               input logic cin);
    logic [PIX_W-1:0] s;
    logic c;
    s = '0;
    c = cin;
    for (int i = 0; i < PIX_W; i++) begin
      s[i] = (a[i] & en[i]) ^ (b[i] & en[i]) ^ (c & en[i]);
      c = (((a[i] & b[i]) | (c & (a[i] ^ b[i]))) & en[i]) & cm[i];
    end
    return s; // Final carry dropped: nothing leaves the top bit.
  endfunction

  // Additive mix output and masked compare (equal on every enabled bit; the carry mask is not used).
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mix_out <= '0;
      cmp_eq_out <= 1'b0;
    end else begin
      mix_out <= seg_add(dst_pix_in, operand, pix_mask_in, carry_propagate_mask_r[PIX_W-1:0], 1'b0);
      cmp_eq_out <= ((dst_pix_in & pix_mask_in) == (cmp_val_in & pix_mask_in));
    end
  end
endmodule
`default_nettype wire

// ### inc/dcp_regs.svh
// Register offsets, field positions, reset values and limits of the drawing coprocessor parameter bank.
`ifndef DCP_REGS_SVH
`define DCP_REGS_SVH
`define DCP_OFF_CARRY 8'h54
`define DCP_OFF_FRONT 8'h58
`define DCP_OFF_BACK 8'h5C
`define DCP_OFF_DIM1 8'h60
`define DCP_OFF_DIM2 8'h62
`define DCP_OFF_MASKX 8'h6C
`define DCP_OFF_MASKY 8'h6E
`define DCP_OFF_SRCX 8'h70
`define DCP_OFF_SRCY 8'h72
`define DCP_OFF_PATX 8'h74
`define DCP_OFF_PATY 8'h76
`define DCP_OFF_DSTX 8'h78
`define DCP_OFF_DSTY 8'h7A
`define DCP_OFF_PIXOP 8'h7C
`define DCP_OFF_CTRL 8'h80
`define DCP_OFF_STAT 8'h84
`define DCP_POS_BS 30
`define DCP_POS_FS 28
`define DCP_POS_STEP 24
`define DCP_RST_WORD 32'h0000_0000
`define DCP_RST_HALF 16'h0000
`define DCP_UMAX 16'h0FFF
`define DCP_SEL_FIXED 2'h0
`define DCP_SEL_SRCMAP 2'h2
`endif

// ### inc/dcp_pkg.sv
// Types shared by both ends of the drawing coprocessor parameter link.
package dcp_pkg;
  // Which half-words of a register write are valid.
  typedef logic [1:0] dcp_lanes_t;
  // Host-side sequencer states.
  typedef enum logic [1:0] {DCP_IDLE, DCP_WR, DCP_RD, DCP_WAIT} dcp_host_state_t;
endpackage

// ### inc/dcp_if.sv
// Interface joining the host register port and the coprocessor register bank.
`timescale 1ns/100ps
`default_nettype none
interface dcp_if;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  modport dev (input addr, input wdata, input be, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output be, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// ### verilog/dcp_host.sv
// Host end: turns user commands into single-cycle writes and reads on the register port.
`timescale 1ns/100ps
`default_nettype none
`include "dcp_regs.svh"
module dcp_host
  import dcp_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic nrst_in,
  // Register port toward the coprocessor.
  dcp_if.host bus,
  // User command port.
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] be_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic rvalid_out,
  output logic range_err_out
);
  dcp_host_state_t state_r; // Sequencer state.

  // Checks unsigned operand limits for dimension, mask origin, source and pattern.
  function automatic logic bad_unsigned(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic in_set;
    in_set = ({a[7:2], 2'b00} == `DCP_OFF_DIM1) || ({a[7:2], 2'b00} == `DCP_OFF_MASKX) ||
             ({a[7:2], 2'b00} == `DCP_OFF_SRCX) || ({a[7:2], 2'b00} == `DCP_OFF_PATX);
    return in_set && (((|be[1:0]) && d[15:0] > `DCP_UMAX) || ((|be[3:2]) && d[31:16] > `DCP_UMAX));
  endfunction

  // Issue one strobe per command; out-of-range writes are dropped and flagged.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= DCP_IDLE;
      bus.addr <= 8'h00;
      bus.wdata <= `DCP_RST_WORD;
      bus.be <= 4'h0;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      range_err_out <= 1'b0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      range_err_out <= 1'b0;
      unique case (state_r)
        DCP_IDLE, DCP_WR, DCP_WAIT: begin
          state_r <= DCP_IDLE;
          if (wr_in) begin
            if (bad_unsigned(addr_in, wdata_in, be_in)) begin
              range_err_out <= 1'b1;
            end else begin
              bus.addr <= addr_in;
              bus.wdata <= wdata_in; // callers send byte three last.
              bus.be <= be_in;
              bus.wr <= 1'b1;
              state_r <= DCP_WR;
            end
          end else if (rd_in) begin
            bus.addr <= addr_in;
            bus.rd <= 1'b1;
            state_r <= DCP_RD;
          end
        end
        DCP_RD: begin
          state_r <= DCP_WAIT;
        end
      endcase
    end
  end

  // Capture read data in the wait state: the bank registers its answer on the edge that leaves the read state,
  // so sampling one edge earlier would pick up the previous read's word.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= `DCP_RST_WORD;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= (state_r == DCP_WAIT);
      if (state_r == DCP_WAIT) begin
        rdata_out <= bus.rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/dcp_param_regs_properties.sv
// Concurrent checks on the register port that joins the host end and the coprocessor bank.
`timescale 1ns/100ps
`default_nettype none
module dcp_port_checker (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic nrst_in,
  // Register port signals.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata
);
  // Shadow words of the readable coordinates, used to predict read data.
  logic [31:0] src_r, pat_r, dst_r;
  // Merges the enabled byte lanes of a write into a shadow word.
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      if (b[i]) o[i*8+:8] = n[i*8+:8];
    end
    return o;
  endfunction
  // The shadows follow writes at exactly 0x70, 0x74 and 0x78; they clear like the bank.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_r <= 32'h0000_0000;
      pat_r <= 32'h0000_0000;
      dst_r <= 32'h0000_0000;
    end else if (wr) begin
      if (addr == 8'h70) src_r <= mrg(src_r, wdata, be);
      if (addr == 8'h74) pat_r <= mrg(pat_r, wdata, be);
      if (addr == 8'h78) dst_r <= mrg(dst_r, wdata, be);
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // Strobes never meet.
  property p_excl; !(wr && rd); endproperty
  a_excl: assert property (p_excl) else $error("write and read strobes together");
  // Read data changes only in the cycle after a read.
  property p_stands; !rd |=> $stable(rdata); endproperty
  a_stands: assert property (p_stands) else $error("read data moved without a read");
  // A read strobe is never followed by another read strobe in the next cycle.
  property p_rd_one; rd |=> !rd; endproperty
  a_rd_one: assert property (p_rd_one) else $error("read strobe longer than one cycle");
  property p_wo_zero; rd && (addr inside {8'h54, 8'h58, 8'h5C, 8'h60, 8'h6C, 8'h7C, 8'h80}) |=> rdata == 32'h0; endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("write-only read not zero");
  property p_src; rd && addr == 8'h70 |=> rdata == src_r; endproperty
  a_src: assert property (p_src) else $error("source word read wrong");
  property p_pat; rd && addr == 8'h74 |=> rdata == pat_r; endproperty
  a_pat: assert property (p_pat) else $error("pattern word read wrong");
  property p_dst; rd && addr == 8'h78 |=> rdata == dst_r; endproperty
  a_dst: assert property (p_dst) else $error("destination word read wrong");
  // Range-checked words never carry an out-of-range half onto the port.
  property p_range;
    wr && (addr inside {8'h60, 8'h6C, 8'h70, 8'h74}) |-> wdata[15:0] <= 16'h0FFF && wdata[31:16] <= 16'h0FFF;
  endproperty
  a_range: assert property (p_range) else $error("out-of-range value reached the bank");
endmodule
`default_nettype wire

// ### tb/tb_drawing_coprocessor_param_regs.sv
// Self-checking bench for the host end and the coprocessor bank joined by their interface.
`timescale 1ns/100ps
`default_nettype none
module tb_drawing_coprocessor_param_regs;
  // User-side stimulus, all given a value at time zero.
  logic clock_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, pat_pix = 1'b0, done_in = 1'b0;
  logic [7:0] addr_in = 8'h00, src_pix = 8'h00, dst_pix = 8'h00, pix_mask = 8'h00, cmp_val = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic step = 1'b0; // Advance request for the coordinate counters.
  logic [3:0] be_in = 4'h0;
  // Observed outputs.
  logic [31:0] rdata_out, pixel_op_out;
  logic rvalid_out, range_err_out, cmp_eq_out, start_out, busy_out;
  logic [7:0] mix_out;
  logic [15:0] dim1_out, dim2_out, mask_x_out, mask_y_out, dst_x_out, dst_y_out;
  int bad_count = 0, n_checks = 0, seed = 75, n_start = 0, n_err = 0, cyc = 0;
  // Reference register words indexed by offset.
  logic [31:0] mdl [0:255];
  dcp_if bus_if ();
  dcp_device #(.PIX_W(8)) dcp_device_i (.clock_in(clock_in), .nrst_in(nrst_in), .bus(bus_if),
    .src_pix_in(src_pix), .dst_pix_in(dst_pix), .pat_pix_in(pat_pix), .pix_mask_in(pix_mask),
    .cmp_val_in(cmp_val), .step_in(step), .done_in(done_in), .mix_out(mix_out), .cmp_eq_out(cmp_eq_out),
    .start_out(start_out), .busy_out(busy_out), .pixel_op_out(pixel_op_out), .dim1_out(dim1_out),
    .dim2_out(dim2_out), .mask_x_out(mask_x_out), .mask_y_out(mask_y_out), .dst_x_out(dst_x_out),
    .dst_y_out(dst_y_out));
  dcp_host dcp_host_i (.clock_in(clock_in), .nrst_in(nrst_in), .bus(bus_if), .addr_in(addr_in),
    .wdata_in(wdata_in), .be_in(be_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .range_err_out(range_err_out));
  dcp_port_checker dcp_port_checker_i (.clock_in(clock_in), .nrst_in(nrst_in), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .be(bus_if.be), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));
  initial forever #25 clock_in = ~clock_in;
  // Pulse counters and the hang guard; pulses are counted so no one-cycle event is missed.
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (start_out === 1'b1) n_start <= n_start + 1;
    if (range_err_out === 1'b1) n_err <= n_err + 1;
    if (cyc == 20000) begin
      $display("[FAIL] %0t run did not finish", $time);
      bad_count = bad_count + 1;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_p(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t pixel got %h expected %h", $time, got, exp);
    end
  endtask
  // One host write; the model drops what the host must refuse, then the bank is given time to settle.
  task automatic hwr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clock_in);
    {addr_in, wdata_in, be_in, wr_in} <= {a, d, b, 1'b1};
    @(posedge clock_in);
    wr_in <= 1'b0;
    if (!((a inside {8'h60, 8'h6C, 8'h70, 8'h74}) && (d[15:0] > 16'h0FFF || d[31:16] > 16'h0FFF))) begin
      for (int i = 0; i < 4; i++) if (b[i]) mdl[a][i*8+:8] = d[i*8+:8];
    end
    repeat (3) @(posedge clock_in);
  endtask
  // One host read, waiting a bounded time for the valid pulse.
  task automatic hrd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    {addr_in, rd_in} <= {a, 1'b1};
    @(posedge clock_in);
    rd_in <= 1'b0;
    d = 32'hXXXX_XXXX;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_in);
      #1;
      if (rvalid_out === 1'b1) begin
        d = rdata_out;
        break;
      end
    end
  endtask
  // Segmented add: a clear carry-mask bit stops the carry, a disabled bit yields 0 and passes none.
  function automatic logic [7:0] mix_m(input logic [7:0] d, input logic [7:0] o, input logic [7:0] m,
                                       input logic [7:0] c);
    logic cy;
    mix_m = 8'h00;
    cy = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        mix_m[i] = d[i] ^ o[i] ^ cy;
        cy = c[i] & ((d[i] & o[i]) | (cy & (d[i] ^ o[i])));
      end else begin
        cy = 1'b0;
      end
    end
  endfunction
  initial begin
    logic [31:0] d, cm, fc, bc;
    logic [7:0] a, op, s8, d8, m8;
    logic [3:0] b;
    int s;
    for (int i = 0; i < 256; i++) mdl[i] = 32'h0000_0000;
    repeat (12) @(posedge clock_in);
    nrst_in <= 1'b1;
    // Cleared words and write-only places all read zero.
    foreach (mdl[i]) if (i inside {8'h54, 8'h70, 8'h74, 8'h78, 8'h7C, 8'h80}) begin
      hrd(i[7:0], d);
      chk_w(d, 32'h0000_0000);
    end
    $display("test reset done");
    // Random partial writes to the readable coordinates, read back whole.
    for (int i = 0; i < 12; i++) begin
      a = 8'h70 + 8'h04 * 8'($unsigned($random(seed)) % 3);
      b = 4'($random(seed));
      if (b == 4'h0) b = 4'hF;
      hwr(a, $random(seed) & 32'h0FFF_0FFF, b);
      hrd(a, d);
      chk_w(d, mdl[a]);
    end
    chk_w(n_err, 0);
    hwr(8'h78, 32'h17FF_F800, 4'hF);
    hrd(8'h78, d);
    chk_w(d, 32'h17FF_F800);
    chk_w({dst_y_out, dst_x_out}, 32'h17FF_F800);
    $display("test coordinates done");
    // Dimensions and mask offsets, then a high-half-only write and a refused out-of-range write.
    hwr(8'h60, 32'h0002_0009, 4'hF);
    hwr(8'h6C, 32'h0FFF_0005, 4'hF);
    hwr(8'h60, 32'h0FFF_0000, 4'hC);
    chk_w({dim2_out, dim1_out}, mdl[8'h60]);
    chk_w({mask_y_out, mask_x_out}, mdl[8'h6C]);
    s = n_err;
    hwr(8'h60, 32'h0000_1000, 4'hF);
    chk_w(n_err - s, 1);
    chk_w({dim2_out, dim1_out}, mdl[8'h60]);
    $display("test dimensions done");
    // Lower bytes of the pixel operation alone start nothing.
    s = n_start;
    hwr(8'h7C, 32'h0012_3456, 4'h7);
    chk_w(n_start - s, 0);
    chk_p(busy_out, 1'b0);
    // Every source code in turn: launch, harmless read, status, then pixel results.
    for (int k = 0; k < 4; k++) begin
      cm = $random(seed);
      fc = $random(seed);
      bc = $random(seed);
      hwr(8'h54, cm, 4'hF);
      hwr(8'h58, fc, 4'hF);
      hwr(8'h5C, bc, 4'hF);
      s = n_start;
      hwr(8'h7C, {2'(k), 2'(k), 4'h8, 24'h112340}, 4'hF);
      chk_w(n_start - s, 1);
      chk_w(pixel_op_out, mdl[8'h7C]);
      hrd(8'h7C, d);
      chk_w(d, 32'h0000_0000);
      hrd(8'h84, d);
      chk_p(d[0], 1'b1);
      // One step while busy moves every X coordinate on by one; no later read touches the stepped words.
      @(posedge clock_in);
      step <= 1'b1;
      @(posedge clock_in);
      step <= 1'b0;
      done_in <= 1'b1;
      mdl[8'h78][15:0] = mdl[8'h78][15:0] + 16'h0001;
      @(posedge clock_in);
      done_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      chk_p(busy_out, 1'b0);
      chk_w({dst_y_out, dst_x_out}, mdl[8'h78]);
      for (int j = 0; j < 12; j++) begin
        {s8, d8, m8} = 24'($random(seed));
        if (j < 4) m8 = 8'hFF;
        @(posedge clock_in);
        {src_pix, dst_pix, pix_mask, pat_pix} <= {s8, d8, m8, 1'(j)};
        cmp_val <= j[1] ? d8 ^ (~m8 & s8) : s8;
        @(posedge clock_in);
        #1;
        op = (j % 2 == 1) ? ((k == 2) ? s8 : fc[7:0]) : ((k == 2) ? s8 : bc[7:0]);
        chk_p(mix_out, mix_m(d8, op, m8, cm[7:0]));
        chk_p(cmp_eq_out, ((d8 ^ cmp_val) & m8) == 8'h00);
      end
    end
    $display("test pixel operations done");
    print_verdict();
  end
endmodule
`default_nettype wire
